/* File: rtl/framer_error_counters_loopback.sv */
// error counters, update timing and loopback routing for one framer channel
//
// Added by the designer: the strobed register port.
`timescale 1ns/1ns
`include "framer_err_regs.svh"

// Overview of operation
// - T1 update each second or 333 frames
// - E1 update each second or 500 frames
// - accumulation mode picks timed or manual update
// - E1 line count: bipolar or code violations
// - path count adds Fs errors when enabled
// - out-of-sync counts framing errors or multiframes
// - T1 line count optionally adds excessive zeros
// - 16-bit counts, high byte at even address
// - local loop feeds transmit data to receive
// - remote loop echoes receive line to transmit
// - payload loop times transmit from recovered clock
// - T1 payload loops 192 bits, regenerates overhead
// - E1 payload loops 248 bits, regenerates overhead
// - framer loop; T1 sends unframed all ones
// - framer loop ignores line, uses transmit timing
// - per-channel bit loops receive slot to transmit
// - manual bit rising edge latches and clears counters
module framer_error_counters_loopback
	import framer_err_pkg::*;
#(
	parameter int ONE_SEC_CYCLES = `ONE_SECOND_NS / `REF_CLK_NS
) (
	input  wire logic       ref_clk,
	input  wire logic       arst_n,
	input  wire logic [7:0] regAddr,
	input  wire logic [7:0] regWdata,
	input  wire logic       regWr,
	input  wire logic       regRd,
	output logic      [7:0] regRdata,
	output logic            irq,
	input  wire logic       recovered_rx_clock,
	input  wire logic       tx_line_clock,
	input  wire logic       rx_line_positive_in,
	input  wire logic       rx_line_negative_in,
	input  wire logic       fmtPosIn,
	input  wire logic       fmtNegIn,
	input  wire logic       bpvIn,
	input  wire logic       cvIn,
	input  wire logic       exZerosIn,
	input  wire logic       ftErrIn,
	input  wire logic       fsErrIn,
	input  wire logic       fbitErrIn,
	input  wire logic       mfOosIn,
	input  wire logic       ebitErrIn,
	input  wire logic       frameMarkIn,
	input  wire logic [4:0] txSlot,
	output logic            tx_line_positive_out,
	output logic            tx_line_negative_out,
	output logic            rxFramerPos,
	output logic            rxFramerNeg,
	output logic            rxTimingFromTx,
	output logic            jitterAttenLoop,
	output logic            ignoreTxSerial,
	output logic            regenOverhead,
	output logic            chanLoopActive
);
	pinIn_t                 pinRaw;
	pinIn_t                 sync1_r;
	pinIn_t                 sync2_r;
	logic                   recPrev_r;
	logic                   txPrev_r;
	errCfg_t                cfg_r;
	loopCtl_t               loop_r;
	logic [`LOOP_CHANNELS-1:0] chanEn_r;
	logic [1:0]             irqStat_r;
	logic [1:0]             irqMask_r;
	logic                   e1Mode_r;
	logic                   manualPrev_r;
	logic [26:0]            secCnt_r;
	logic [9:0]             frameCnt_r;
	logic                   amiPhase_r;
	count_t                 cnt_r  [4];
	count_t                 held_r [4];
	logic [3:0]             cntEvent;
	logic [3:0]             satHit;
	logic                   recRise;
	logic                   txRise;
	logic                   cntTick;
	logic                   txTick;
	logic                   secHit;
	logic                   frameHit;
	logic                   manualRise;
	logic                   updateNow;
	logic [9:0]             fastFrames;
	logic [1:0]             irqSet;
	logic [7:0]             rdNxt;

	assign pinRaw = '{recClk: recovered_rx_clock, txClk: tx_line_clock,
		rxPos: rx_line_positive_in, rxNeg: rx_line_negative_in, fmtPos: fmtPosIn, fmtNeg: fmtNegIn,
		bpv: bpvIn, cv: cvIn, exZeros: exZerosIn, ftErr: ftErrIn, fsErr: fsErrIn,
		fbitErr: fbitErrIn, mfOos: mfOosIn, ebitErr: ebitErrIn, frameMark: frameMarkIn};

	// two-stage synchroniser for every line-side input
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			sync1_r <= '0;
			sync2_r <= '0;
			recPrev_r <= 1'b0;
			txPrev_r <= 1'b0;
		end else begin
			sync1_r <= pinRaw;
			sync2_r <= sync1_r;
			recPrev_r <= sync2_r.recClk;
			txPrev_r <= sync2_r.txClk;
		end
	end

	assign recRise = sync2_r.recClk & ~recPrev_r;
	assign txRise = sync2_r.txClk & ~txPrev_r;
	assign cntTick = loop_r.framer_loop ? txRise : recRise;
	assign txTick = (loop_r.payload_loop && !loop_r.framer_loop) ? recRise : txRise;

	// count sources per counter
	always_comb begin
		if (e1Mode_r) begin
			cntEvent[0] = cfg_r.e1_violation_source_select ? sync2_r.cv : sync2_r.bpv;
		end else begin
			cntEvent[0] = sync2_r.bpv | (cfg_r.excessive_zeros_select & sync2_r.exZeros);
		end
		cntEvent[1] = sync2_r.ftErr | (cfg_r.fs_bit_report_enable & sync2_r.fsErr);
		cntEvent[2] = cfg_r.multiframe_count_select ? sync2_r.mfOos : sync2_r.fbitErr;
		cntEvent[3] = sync2_r.ebitErr;
	end

	// update period timing
	assign fastFrames = e1Mode_r ? `E1_FAST_FRAMES : `T1_FAST_FRAMES;
	assign secHit = (secCnt_r == 27'(ONE_SEC_CYCLES - 1));
	assign frameHit = cntTick && sync2_r.frameMark && (frameCnt_r == fastFrames - 10'd1);
	assign manualRise = cfg_r.manual_count_latch & ~manualPrev_r;

	always_comb begin
		if (cfg_r.accumulation_mode_select) begin
			updateNow = manualRise;
		end else if (cfg_r.update_period_select) begin
			updateNow = frameHit;
		end else begin
			updateNow = secHit;
		end
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			secCnt_r <= '0;
			frameCnt_r <= '0;
			manualPrev_r <= 1'b0;
		end else begin
			manualPrev_r <= cfg_r.manual_count_latch;
			secCnt_r <= secHit ? 27'd0 : secCnt_r + 27'd1;
			if (frameHit) begin
				frameCnt_r <= '0;
			end else if (cntTick && sync2_r.frameMark) begin
				frameCnt_r <= frameCnt_r + 10'd1;
			end
		end
	end

	// saturating counters and held copies
	generate
		for (genvar i = 0; i < 4; i++) begin : g_cnt
			assign satHit[i] = cntTick && cntEvent[i] && (cnt_r[i] == `COUNT_MAX - 16'd1);
			always_ff @(posedge ref_clk or negedge arst_n) begin
				if (!arst_n) begin
					cnt_r[i] <= '0;
					held_r[i] <= '0;
				end else if (updateNow) begin
					held_r[i] <= cnt_r[i];
					cnt_r[i] <= (cntTick && cntEvent[i]) ? 16'd1 : 16'd0;
				end else if (cntTick && cntEvent[i] && cnt_r[i] != `COUNT_MAX) begin
					cnt_r[i] <= cnt_r[i] + 16'd1;
				end
			end
		end
	endgenerate

	// register writes
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			cfg_r <= `RESET_BYTE;
			loop_r <= '0;
			chanEn_r <= '0;
			irqMask_r <= '0;
			e1Mode_r <= 1'b0;
		end else if (regWr) begin
			case (regAddr)
				`ADDR_ERR_CFG: cfg_r <= regWdata & `ERR_CFG_MASK;
				`ADDR_LOOP_CTL: loop_r <= regWdata[4:0];
				`ADDR_CHAN_LOOP1: chanEn_r[7:0] <= regWdata;
				`ADDR_CHAN_LOOP2: chanEn_r[15:8] <= regWdata;
				`ADDR_CHAN_LOOP3: chanEn_r[23:16] <= regWdata;
				`ADDR_IRQ_MASK: irqMask_r <= regWdata[1:0];
				`ADDR_LINE_MODE: e1Mode_r <= regWdata[`MODE_E1_BIT];
				default: ;
			endcase
		end
	end

	// sticky status, set beats write-one-to-clear
	assign irqSet[`IRQ_UPDATE_BIT] = updateNow;
	assign irqSet[`IRQ_SATURATE_BIT] = |satHit;

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			irqStat_r <= '0;
			irq <= 1'b0;
		end else begin
			if (regWr && regAddr == `ADDR_IRQ_STATUS) begin
				irqStat_r <= (irqStat_r & ~regWdata[1:0]) | irqSet;
			end else begin
				irqStat_r <= irqStat_r | irqSet;
			end
			irq <= |(irqStat_r & irqMask_r);
		end
	end

	// read mux, data one cycle after strobe
	always_comb begin
		case (regAddr)
			`ADDR_ERR_CFG: rdNxt = cfg_r;
			`ADDR_LCV_HI: rdNxt = held_r[0][15:8];
			`ADDR_LCV_LO: rdNxt = held_r[0][7:0];
			`ADDR_PCV_HI: rdNxt = held_r[1][15:8];
			`ADDR_PCV_LO: rdNxt = held_r[1][7:0];
			`ADDR_FOS_HI: rdNxt = held_r[2][15:8];
			`ADDR_FOS_LO: rdNxt = held_r[2][7:0];
			`ADDR_EB_HI: rdNxt = held_r[3][15:8];
			`ADDR_EB_LO: rdNxt = held_r[3][7:0];
			`ADDR_LOOP_CTL: rdNxt = {3'b000, loop_r};
			`ADDR_CHAN_LOOP1: rdNxt = chanEn_r[7:0];
			`ADDR_CHAN_LOOP2: rdNxt = chanEn_r[15:8];
			`ADDR_CHAN_LOOP3: rdNxt = chanEn_r[23:16];
			`ADDR_IRQ_STATUS: rdNxt = {6'b00_0000, irqStat_r};
			`ADDR_IRQ_MASK: rdNxt = {6'b00_0000, irqMask_r};
			`ADDR_LINE_MODE: rdNxt = {7'b000_0000, e1Mode_r};
			default: rdNxt = `RESET_BYTE;
		endcase
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			regRdata <= `RESET_BYTE;
		end else begin
			regRdata <= regRd ? rdNxt : `RESET_BYTE;
		end
	end

	// transmit line routing
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			tx_line_positive_out <= 1'b0;
			tx_line_negative_out <= 1'b0;
			amiPhase_r <= 1'b0;
		end else if (txTick) begin
			if (loop_r.framer_loop && !e1Mode_r) begin
				amiPhase_r <= ~amiPhase_r;
				tx_line_positive_out <= amiPhase_r;
				tx_line_negative_out <= ~amiPhase_r;
			end else if (loop_r.remote_loop && !loop_r.framer_loop && !loop_r.payload_loop) begin
				tx_line_positive_out <= sync2_r.rxPos;
				tx_line_negative_out <= sync2_r.rxNeg;
			end else begin
				tx_line_positive_out <= sync2_r.fmtPos;
				tx_line_negative_out <= sync2_r.fmtNeg;
			end
		end
	end

	// receive framer routing and loop controls
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			rxFramerPos <= 1'b0;
			rxFramerNeg <= 1'b0;
			rxTimingFromTx <= 1'b0;
			jitterAttenLoop <= 1'b0;
			ignoreTxSerial <= 1'b0;
			regenOverhead <= 1'b0;
		end else begin
			rxTimingFromTx <= loop_r.framer_loop;
			jitterAttenLoop <= loop_r.local_loop & ~loop_r.framer_loop;
			ignoreTxSerial <= loop_r.payload_loop;
			regenOverhead <= loop_r.payload_loop;
			if (cntTick) begin
				if (loop_r.framer_loop) begin
					rxFramerPos <= sync2_r.fmtPos;
					rxFramerNeg <= sync2_r.fmtNeg;
				end else if (loop_r.local_loop) begin
					rxFramerPos <= tx_line_positive_out;
					rxFramerNeg <= tx_line_negative_out;
				end else begin
					rxFramerPos <= sync2_r.rxPos;
					rxFramerNeg <= sync2_r.rxNeg;
				end
			end
		end
	end

	// per-channel loop select for the current transmit slot
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			chanLoopActive <= 1'b0;
		end else begin
			chanLoopActive <= (txSlot >= 5'd1) && (txSlot <= 5'd24) && chanEn_r[txSlot - 5'd1];
		end
	end

	default clocking @(posedge ref_clk); endclocking
	default disable iff (!arst_n);

	AST_T1_FAST_UPDATE: assert property (
		!e1Mode_r && !cfg_r.accumulation_mode_select && cfg_r.update_period_select && cntTick
		&& sync2_r.frameMark && frameCnt_r == 10'd332 |=> held_r[0] == $past(cnt_r[0]))
		else $error("t1 fast update missed");
	AST_E1_FAST_UPDATE: assert property (
		e1Mode_r && !cfg_r.accumulation_mode_select && cfg_r.update_period_select && cntTick
		&& sync2_r.frameMark && frameCnt_r == 10'd499 |=> irqStat_r[0])
		else $error("e1 fast update missed");
	AST_MANUAL_ONLY: assert property (
		cfg_r.accumulation_mode_select && !manualRise |=> $stable(held_r[1]))
		else $error("held count moved without manual latch");
	AST_MANUAL_LATCH: assert property (
		cfg_r.accumulation_mode_select && manualRise && !(cntTick && cntEvent[2])
		|=> held_r[2] == $past(cnt_r[2]) && cnt_r[2] == 16'd0)
		else $error("manual latch failed");
	AST_E1_BPV: assert property (
		e1Mode_r && !cfg_r.e1_violation_source_select && cntTick && sync2_r.bpv && !updateNow
		&& cnt_r[0] != 16'hFFFF |=> cnt_r[0] == $past(cnt_r[0]) + 16'd1)
		else $error("bipolar violation not counted");
	AST_FS_IGNORED: assert property (
		!cfg_r.fs_bit_report_enable && sync2_r.fsErr && !sync2_r.ftErr && !updateNow |=> $stable(cnt_r[1]))
		else $error("fs error counted while disabled");
	AST_MF_COUNT: assert property (
		cfg_r.multiframe_count_select && cntTick && sync2_r.mfOos && !updateNow
		&& cnt_r[2] != 16'hFFFF |=> cnt_r[2] == $past(cnt_r[2]) + 16'd1)
		else $error("multiframe slip not counted");
	AST_EXZ_COUNT: assert property (
		!e1Mode_r && cfg_r.excessive_zeros_select && cntTick && sync2_r.exZeros && !updateNow
		&& cnt_r[0] != 16'hFFFF |=> cnt_r[0] == $past(cnt_r[0]) + 16'd1)
		else $error("excessive zeros not counted");
	AST_HIGH_BYTE: assert property (
		regRd && regAddr == 8'h42 |=> regRdata == $past(held_r[0][15:8]))
		else $error("high byte read wrong");
	AST_REMOTE_ECHO: assert property (
		txTick && loop_r.remote_loop && !loop_r.framer_loop && !loop_r.payload_loop
		|=> tx_line_positive_out == $past(sync2_r.rxPos))
		else $error("remote loop not echoing");
	AST_FRAMER_ONES: assert property (
		txTick && loop_r.framer_loop && !e1Mode_r |=> tx_line_positive_out != tx_line_negative_out)
		else $error("framer loop not sending ones");
	AST_SATURATE: assert property (
		cnt_r[3] == 16'hFFFF && !updateNow |=> cnt_r[3] == 16'hFFFF)
		else $error("counter wrapped");
	AST_LOCAL_LOOP: assert property (
		cntTick && loop_r.local_loop && !loop_r.framer_loop |=> rxFramerPos == $past(tx_line_positive_out))
		else $error("local loop not feeding receive side");
	AST_JITTER_PATH: assert property (
		loop_r.local_loop && !loop_r.framer_loop |=> jitterAttenLoop)
		else $error("local loop bypasses jitter path");
	AST_FRAMER_RX: assert property (
		cntTick && loop_r.framer_loop |=> rxFramerPos == $past(sync2_r.fmtPos) && rxTimingFromTx)
		else $error("framer loop receive path wrong");
	AST_PAYLOAD_FLAGS: assert property (
		loop_r.payload_loop |=> ignoreTxSerial && regenOverhead)
		else $error("payload loop flags missing");
	AST_PAYLOAD_TIMING: assert property (
		loop_r.payload_loop && !loop_r.framer_loop && !recRise |=> $stable(tx_line_positive_out))
		else $error("payload loop transmit not on recovered clock");
	AST_CHAN_LOOP: assert property (
		txSlot == 5'd1 && chanEn_r[0] |=> chanLoopActive)
		else $error("channel one loop not active");
endmodule

/* File: rtl/framer_err_regs.svh */
// register offsets, field positions, reset values and timing counts
`ifndef FRAMER_ERR_REGS_SVH
`define FRAMER_ERR_REGS_SVH
`define ADDR_ERR_CFG       8'h41
`define ADDR_LCV_HI        8'h42
`define ADDR_LCV_LO        8'h43
`define ADDR_PCV_HI        8'h44
`define ADDR_PCV_LO        8'h45
`define ADDR_FOS_HI        8'h46
`define ADDR_FOS_LO        8'h47
`define ADDR_EB_HI         8'h48
`define ADDR_EB_LO         8'h49
`define ADDR_LOOP_CTL      8'h4A
`define ADDR_CHAN_LOOP1    8'h4B
`define ADDR_CHAN_LOOP2    8'h4C
`define ADDR_CHAN_LOOP3    8'h4D
`define ADDR_IRQ_STATUS    8'h60
`define ADDR_IRQ_MASK      8'h61
`define ADDR_LINE_MODE     8'h62
`define RESET_BYTE         8'h00
`define LOOP_CTL_MASK      8'h1F
`define ERR_CFG_MASK       8'h7F
`define IRQ_BITS_MASK      8'h03
`define IRQ_UPDATE_BIT     0
`define IRQ_SATURATE_BIT   1
`define MODE_E1_BIT        0
`define COUNT_MAX          16'hFFFF
`define T1_FAST_FRAMES     10'd333
`define E1_FAST_FRAMES     10'd500
`define T1_FAST_MS         42
`define E1_FAST_US         62500
`define ONE_SECOND_NS      1000000000
`define REF_CLK_NS         8
`define LOOP_CHANNELS      24
`endif

/* File: rtl/framer_err_pkg.sv */
// types shared by the error-counter and loopback block
package framer_err_pkg;
	typedef struct packed {
		logic reserved0;
		logic manual_count_latch;
		logic update_period_select;
		logic accumulation_mode_select;
		logic e1_violation_source_select;
		logic fs_bit_report_enable;
		logic multiframe_count_select;
		logic excessive_zeros_select;
	} errCfg_t;

	typedef struct packed {
		logic reserved4;
		logic local_loop;
		logic remote_loop;
		logic payload_loop;
		logic framer_loop;
	} loopCtl_t;

	typedef struct packed {
		logic recClk;
		logic txClk;
		logic rxPos;
		logic rxNeg;
		logic fmtPos;
		logic fmtNeg;
		logic bpv;
		logic cv;
		logic exZeros;
		logic ftErr;
		logic fsErr;
		logic fbitErr;
		logic mfOos;
		logic ebitErr;
		logic frameMark;
	} pinIn_t;

	typedef logic [15:0] count_t;
endpackage

/* File: dv/line_partner.sv */
// line-side model: link clocks in bursts, line data, formatter data and error flags
`timescale 1ns/1ns
module line_partner
	import framer_err_pkg::*;
(
	input  wire logic [1:0] lineIn,
	input  wire logic [1:0] fmtIn,
	input  wire logic [7:0] flagsIn,
	input  wire logic       markEn,
	output pinIn_t          pins
);
	logic recClk = 1'b0;
	logic txClk = 1'b0;

	// clocks stand still between bursts, 64 ns period inside them; edges kept off the sampling edges
	task automatic burst(input int n);
		#3;
		for (int i = 0; i < n; i++) begin
			#16 recClk = 1'b1;
			#16 txClk = 1'b1;
			#16 recClk = 1'b0;
			#16 txClk = 1'b0;
		end
	endtask

	assign pins = {recClk, txClk, lineIn, fmtIn, flagsIn, markEn};
endmodule

/* File: dv/tb_top.sv */
// self-checking bench for the error-counter and loopback block
`timescale 1ns/1ns
module tb_top
	import framer_err_pkg::*;
;
	typedef struct {logic e1; logic [7:0] cfg; logic [7:0] fl; int n; int idx; logic hit;} crow_t;
	typedef struct {logic [7:0] ctl; logic e1; logic [1:0] tx; logic [1:0] rx; logic [3:0] fl;} lrow_t;
	localparam int SEC = 3000;
	logic       ref_clk = 1'b0;
	logic       arst_n = 1'b0;
	logic [7:0] regAddr = 8'h00;
	logic [7:0] regWdata = 8'h00;
	logic       regWr = 1'b0;
	logic       regRd = 1'b0;
	logic [4:0] txSlot = 5'h00;
	logic [1:0] lineIn = 2'b10;
	logic [1:0] fmtIn = 2'b01;
	logic [7:0] flags = 8'h00;
	logic       markEn = 1'b0;
	logic [7:0] regRdata;
	logic       irq, txP, txN, rxP, rxN, timTx, jitLoop, ignTx, regen, chanLoop;
	pinIn_t     pins;
	int         nErrors = 0;
	int         comparisons = 0;
	int         cyc = 0;
	crow_t      rows[15] = '{'{0, 8'h00, 8'h80, 300, 0, 1}, '{0, 8'h00, 8'h20, 4, 0, 0},
		'{0, 8'h01, 8'h20, 4, 0, 1}, '{1, 8'h00, 8'h40, 3, 0, 0}, '{1, 8'h08, 8'h40, 3, 0, 1},
		'{1, 8'h08, 8'h80, 3, 0, 0}, '{1, 8'h00, 8'h80, 3, 0, 1}, '{0, 8'h00, 8'h08, 6, 1, 0},
		'{0, 8'h04, 8'h08, 6, 1, 1}, '{0, 8'h00, 8'h10, 6, 1, 1}, '{0, 8'h00, 8'h02, 5, 2, 0},
		'{0, 8'h02, 8'h02, 5, 2, 1}, '{0, 8'h02, 8'h04, 5, 2, 0}, '{0, 8'h00, 8'h04, 5, 2, 1},
		'{1, 8'h00, 8'h01, 7, 3, 1}};
	lrow_t      lrows[7] = '{'{8'h00, 0, 2'b01, 2'b10, 4'h0}, '{8'h04, 0, 2'b10, 2'b10, 4'h0},
		'{8'h08, 0, 2'b01, 2'b01, 4'h4}, '{8'h02, 0, 2'b01, 2'b10, 4'h3}, '{8'h02, 1, 2'b01, 2'b10, 4'h3},
		'{8'h01, 0, 2'b11, 2'b01, 4'h8}, '{8'h01, 1, 2'b01, 2'b01, 4'h8}};

	initial begin
		forever #4 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk) cyc <= cyc + 1;

	line_partner line_partner_i (
		.lineIn  (lineIn),
		.fmtIn   (fmtIn),
		.flagsIn (flags),
		.markEn  (markEn),
		.pins    (pins)
	);

	framer_error_counters_loopback #(.ONE_SEC_CYCLES(SEC)) framer_error_counters_loopback_i (
		.ref_clk              (ref_clk),
		.arst_n               (arst_n),
		.regAddr              (regAddr),
		.regWdata             (regWdata),
		.regWr                (regWr),
		.regRd                (regRd),
		.regRdata             (regRdata),
		.irq                  (irq),
		.recovered_rx_clock   (pins.recClk),
		.tx_line_clock        (pins.txClk),
		.rx_line_positive_in  (pins.rxPos),
		.rx_line_negative_in  (pins.rxNeg),
		.fmtPosIn             (pins.fmtPos),
		.fmtNegIn             (pins.fmtNeg),
		.bpvIn                (pins.bpv),
		.cvIn                 (pins.cv),
		.exZerosIn            (pins.exZeros),
		.ftErrIn              (pins.ftErr),
		.fsErrIn              (pins.fsErr),
		.fbitErrIn            (pins.fbitErr),
		.mfOosIn              (pins.mfOos),
		.ebitErrIn            (pins.ebitErr),
		.frameMarkIn          (pins.frameMark),
		.txSlot               (txSlot),
		.tx_line_positive_out (txP),
		.tx_line_negative_out (txN),
		.rxFramerPos          (rxP),
		.rxFramerNeg          (rxN),
		.rxTimingFromTx       (timTx),
		.jitterAttenLoop      (jitLoop),
		.ignoreTxSerial       (ignTx),
		.regenOverhead        (regen),
		.chanLoopActive       (chanLoop)
	);

	task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp) begin
			nErrors++;
			$display("ERROR %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		regAddr <= a;
		regWdata <= d;
		regWr <= 1'b1;
		@(posedge ref_clk);
		regWr <= 1'b0;
		@(posedge ref_clk);
	endtask

	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge ref_clk);
		regRd <= 1'b0;
		@(posedge ref_clk);
		d = regRdata;
	endtask

	task automatic rd16(input logic [7:0] a, output logic [15:0] v);
		logic [7:0] hi, lo;
		rd(a, hi);
		rd(a + 8'h01, lo);
		v = {hi, lo};
	endtask

	task automatic waitIrq(output int t);
		t = -1;
		for (int i = 0; i < SEC + 1000 && t < 0; i++) begin
			@(posedge ref_clk);
			if (irq === 1'b1) t = cyc;
		end
	endtask

	task automatic runFrames(input int n, input logic e);
		line_partner_i.burst(n);
		repeat (8) @(posedge ref_clk);
		chk("frameUpdate", irq, e);
	endtask

	task automatic end_sim();
		if (nErrors == 0 && comparisons > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	initial begin
		#400000;
		nErrors++;
		end_sim();
	end

	initial begin
		logic [7:0]  b;
		logic [15:0] v, w;
		logic [1:0]  tx;
		int          t0, t1;
		repeat (12) @(posedge ref_clk);
		arst_n <= 1'b1;
		@(posedge ref_clk);
		for (int a = 8'h41; a < 8'h63; a++) begin
			rd(8'(a), b);
			chk("resetValue", b, 8'h00);
		end
		wr(8'h42, 8'hAA);
		rd(8'h42, b);
		chk("readOnly", b, 8'h00);
		wr(8'h41, 8'hFF);
		rd(8'h41, b);
		chk("errCfg", b, 8'h7F);
		wr(8'h4A, 8'h0F);
		rd(8'h4A, b);
		chk("loopCtl", b, 8'h0F);
		wr(8'h4B, 8'h81);
		wr(8'h4C, 8'h04);
		wr(8'h4D, 8'h80);
		for (int s = 0; s < 26; s++) begin
			txSlot <= 5'(s);
			repeat (3) @(posedge ref_clk);
			chk("chanLoop", chanLoop, s == 1 || s == 8 || s == 11 || s == 24);
		end
		wr(8'h4D, 8'h00);
		txSlot <= 5'h18;
		repeat (3) @(posedge ref_clk);
		chk("chanOff", chanLoop, 1'b0);
		foreach (rows[i]) begin
			wr(8'h62, {7'h00, rows[i].e1});
			wr(8'h41, 8'h10 | rows[i].cfg);
			wr(8'h41, 8'h50 | rows[i].cfg);
			wr(8'h41, 8'h10 | rows[i].cfg);
			flags <= rows[i].fl;
			repeat (4) @(posedge ref_clk);
			line_partner_i.burst(rows[i].n);
			repeat (8) @(posedge ref_clk);
			wr(8'h41, 8'h50 | rows[i].cfg);
			repeat (13) @(posedge ref_clk);
			for (int r = 0; r < 2; r++) begin
				for (int k = 0; k < 4; k++) begin
					rd16(8'(8'h42 + 2 * k), v);
					w = (k == rows[i].idx && rows[i].hit) ? 16'(rows[i].n) : 16'h0000;
					chk("count", v, w);
				end
				line_partner_i.burst(2);
				repeat (8) @(posedge ref_clk);
			end
		end
		flags <= 8'h00;
		foreach (lrows[i]) begin
			wr(8'h62, {7'h00, lrows[i].e1});
			wr(8'h4A, lrows[i].ctl);
			line_partner_i.burst(4);
			repeat (6) @(posedge ref_clk);
			tx = {txP, txN};
			if (lrows[i].tx == 2'b11) tx = {1'b1, ^tx};
			chk("txLine", tx, lrows[i].tx);
			chk("rxFramer", {rxP, rxN}, lrows[i].rx);
			chk("loopFlags", {timTx, jitLoop, ignTx, regen}, lrows[i].fl);
		end
		wr(8'h4A, 8'h00);
		wr(8'h62, 8'h00);
		wr(8'h41, 8'h00);
		wr(8'h60, 8'h03);
		wr(8'h61, 8'h01);
		repeat (3) @(posedge ref_clk);
		waitIrq(t0);
		wr(8'h60, 8'h01);
		repeat (3) @(posedge ref_clk);
		waitIrq(t1);
		chk("secondGap", 16'(t1 - t0), 16'(SEC));
		wr(8'h41, 8'h20);
		wr(8'h60, 8'h03);
		markEn <= 1'b1;
		repeat (3) @(posedge ref_clk);
		runFrames(332, 1'b0);
		runFrames(1, 1'b1);
		wr(8'h62, 8'h01);
		wr(8'h60, 8'h03);
		repeat (3) @(posedge ref_clk);
		runFrames(499, 1'b0);
		runFrames(1, 1'b1);
		wr(8'h61, 8'h00);
		repeat (2) @(posedge ref_clk);
		chk("irqMasked", irq, 1'b0);
		rd(8'h60, b);
		chk("irqStatus", b, 8'h01);
		wr(8'h61, 8'h01);
		repeat (2) @(posedge ref_clk);
		chk("irqUnmasked", irq, 1'b1);
		wr(8'h60, 8'h01);
		repeat (3) @(posedge ref_clk);
		chk("irqCleared", irq, 1'b0);
		end_sim();
	end
endmodule
